// ### design/msc_pkg.sv
// Package for the motor start-up configuration block: register map, field
// positions, reset values, decoded configuration layout and lookup functions.
// Assumes a single 200 MHz clock domain and byte-wide register access.
package msc_pkg;

  localparam int unsigned MSC_DATA_W = 8;
  localparam int unsigned MSC_ADDR_W = 8;
  localparam int unsigned MSC_NUM_REGS = 5;

  // Register offsets
  localparam logic [7:0] MSC_OFS_ADVANCE = 8'h22;
  localparam logic [7:0] MSC_OFS_DETECT  = 8'h23;
  localparam logic [7:0] MSC_OFS_CURRENT = 8'h24;
  localparam logic [7:0] MSC_OFS_ACCEL   = 8'h25;
  localparam logic [7:0] MSC_OFS_HANDOVR = 8'h26;

  // Register indices
  localparam int unsigned MSC_IDX_ADVANCE = 0;
  localparam int unsigned MSC_IDX_DETECT  = 1;
  localparam int unsigned MSC_IDX_CURRENT = 2;
  localparam int unsigned MSC_IDX_ACCEL   = 3;
  localparam int unsigned MSC_IDX_HANDOVR = 4;

  // Reset values (none given, all zero)
  localparam logic [7:0] MSC_RST_REG = 8'h00;
  localparam logic [7:0] MSC_RDATA_UNMAPPED = 8'h00;

  // Field positions
  localparam int unsigned MSC_ADV_MODE_BIT = 7;
  localparam int unsigned MSC_ADV_SIG_LO   = 0;
  localparam int unsigned MSC_ADV_SHF_LO   = 4;
  localparam int unsigned MSC_STAT_LO      = 6;
  localparam int unsigned MSC_IPD_LO       = 4;
  localparam int unsigned MSC_ISD_EN_BIT   = 3;
  localparam int unsigned MSC_RVS_EN_BIT   = 2;
  localparam int unsigned MSC_RVS_THR_LO   = 0;
  localparam int unsigned MSC_OLCUR_LO     = 6;
  localparam int unsigned MSC_RAMP_LO      = 3;
  localparam int unsigned MSC_BRAKE_LO     = 0;
  localparam int unsigned MSC_ACC2_LO      = 3;
  localparam int unsigned MSC_ACC1_LO      = 0;
  localparam int unsigned MSC_HO_LO        = 3;
  localparam int unsigned MSC_HO_RANGE_BIT = 7;

  // Decoded units
  localparam logic [11:0] MSC_HO_STEP0_DHZ = 12'h008;  // 0.8 Hz in 0.1 Hz
  localparam logic [11:0] MSC_HO_STEP1_DHZ = 12'h080;  // 12.8 Hz in 0.1 Hz
  localparam logic [2:0]  MSC_BRAKE_OFF    = 3'h0;

  typedef enum logic [1:0] {
    MSC_IDLE,
    MSC_OPEN_LOOP,
    MSC_CLOSED_LOOP
  } msc_phase_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [MSC_ADDR_W-1:0] addr;
    logic [MSC_DATA_W-1:0] wdata;
  } msc_regreq_t;

  // Snapshot taken at start-up; units noted per multi-bit field
  typedef struct packed {
    logic        advance_mode_select;          // 0 fixed, 1 variable
    logic [10:0] advance_time_value;           // 2.5 us units
    logic [9:0]  stationary_judge_ms;          // ms
    logic [6:0]  inductive_sense_advance_deg;  // degrees
    logic        initial_speed_detect_enable;
    logic        reverse_drive_enable;
    logic [8:0]  reverse_drive_threshold_dhz;  // 0.1 Hz
    logic [4:0]  open_loop_current_da;         // 0.1 A
    logic [12:0] open_loop_current_ramp_m;     // 0.001 Vcc/s
    logic        brake_enable_flag;
    logic [8:0]  brake_duration_cs;            // 0.01 s
    logic [12:0] startup_accel_second_c;       // 0.01 Hz/s^2
    logic [12:0] startup_accel_first_c;        // 0.01 Hz/s
    logic [11:0] loop_handover_threshold_dhz;  // 0.1 Hz
    logic        loop_handover_valid;
  } msc_cfg_t;

  function automatic logic [9:0] msc_stat_ms(input logic [1:0] c);
    case (c)
      2'h0:    msc_stat_ms = 10'd80;
      2'h1:    msc_stat_ms = 10'd160;
      2'h2:    msc_stat_ms = 10'd320;
      default: msc_stat_ms = 10'd640;
    endcase
  endfunction : msc_stat_ms

  function automatic logic [8:0] msc_rvs_dhz(input logic [1:0] c);
    case (c)
      2'h0:    msc_rvs_dhz = 9'd63;
      2'h1:    msc_rvs_dhz = 9'd130;
      2'h2:    msc_rvs_dhz = 9'd260;
      default: msc_rvs_dhz = 9'd510;
    endcase
  endfunction : msc_rvs_dhz

  function automatic logic [12:0] msc_ramp_m(input logic [2:0] c);
    case (c)
      3'h0: msc_ramp_m = 13'd6000;
      3'h1: msc_ramp_m = 13'd3000;
      3'h2: msc_ramp_m = 13'd1500;
      3'h3: msc_ramp_m = 13'd700;
      3'h4: msc_ramp_m = 13'd340;
      3'h5: msc_ramp_m = 13'd160;
      3'h6: msc_ramp_m = 13'd70;
      default: msc_ramp_m = 13'd23;
    endcase
  endfunction : msc_ramp_m

  function automatic logic [8:0] msc_brake_cs(input logic [2:0] c);
    case (c)
      3'h1: msc_brake_cs = 9'd270;
      3'h2: msc_brake_cs = 9'd130;
      3'h3: msc_brake_cs = 9'd67;
      3'h4: msc_brake_cs = 9'd33;
      3'h5: msc_brake_cs = 9'd16;
      3'h6: msc_brake_cs = 9'd8;
      3'h7: msc_brake_cs = 9'd4;
      default: msc_brake_cs = 9'd0;
    endcase
  endfunction : msc_brake_cs

  function automatic logic [12:0] msc_acc2_c(input logic [2:0] c);
    case (c)
      3'h0: msc_acc2_c = 13'd5700;
      3'h1: msc_acc2_c = 13'd2900;
      3'h2: msc_acc2_c = 13'd1400;
      3'h3: msc_acc2_c = 13'd690;
      3'h4: msc_acc2_c = 13'd330;
      3'h5: msc_acc2_c = 13'd160;
      3'h6: msc_acc2_c = 13'd66;
      default: msc_acc2_c = 13'd22;
    endcase
  endfunction : msc_acc2_c

  function automatic logic [12:0] msc_acc1_c(input logic [2:0] c);
    case (c)
      3'h0: msc_acc1_c = 13'd7600;
      3'h1: msc_acc1_c = 13'd3800;
      3'h2: msc_acc1_c = 13'd1900;
      3'h3: msc_acc1_c = 13'd920;
      3'h4: msc_acc1_c = 13'd450;
      3'h5: msc_acc1_c = 13'd210;
      3'h6: msc_acc1_c = 13'd90;
      default: msc_acc1_c = 13'd30;
    endcase
  endfunction : msc_acc1_c

endpackage : msc_pkg

// ### design/msc_startup_config.sv
// Start-up configuration registers and open/closed loop handover sequencer.
// Assumes register requests and start/stop come from same-clock host-port logic.
`timescale 1ns/1ps

module msc_startup_config #(
  parameter int unsigned FREQ_W = 12
) (
  input  wire logic                           clk_in,
  input  wire logic                           srst_in,
  input  wire msc_pkg::msc_regreq_t           reg_req_in,
  input  wire logic                           start_in,
  input  wire logic                           stop_in,
  input  wire logic [FREQ_W-1:0]              ol_freq_in,
  output logic      [msc_pkg::MSC_DATA_W-1:0] reg_rdata_out,
  output msc_pkg::msc_cfg_t                   cfg_out,
  output msc_pkg::msc_phase_t                 phase_out
);
  import msc_pkg::*;

  // Refused at elaboration: the compare would drop threshold bits
  if (FREQ_W < 12) begin : g_freq_w_check
    $error("FREQ_W must hold the 12-bit handover threshold");
  end
  // Register index is three bits wide
  if (MSC_NUM_REGS > 8) begin : g_num_regs_check
    $error("MSC_NUM_REGS exceeds the register index range");
  end

  logic [MSC_DATA_W-1:0] regs_q [MSC_NUM_REGS];
  logic [MSC_DATA_W-1:0] regs_d [MSC_NUM_REGS];
  logic [MSC_DATA_W-1:0] rdata_q;
  logic [MSC_DATA_W-1:0] rdata_d;
  msc_cfg_t              cfg_q;
  msc_cfg_t              cfg_d;
  msc_cfg_t              live_cfg;
  msc_phase_t            phase_q;
  msc_phase_t            phase_d;
  logic                  hit;
  logic [2:0]            idx;
  logic                  start_take;

  // Register decode
  always_comb begin
    hit = 1'b1;
    idx = 3'(MSC_IDX_ADVANCE);
    case (reg_req_in.addr)
      MSC_OFS_ADVANCE: idx = 3'(MSC_IDX_ADVANCE);
      MSC_OFS_DETECT:  idx = 3'(MSC_IDX_DETECT);
      MSC_OFS_CURRENT: idx = 3'(MSC_IDX_CURRENT);
      MSC_OFS_ACCEL:   idx = 3'(MSC_IDX_ACCEL);
      MSC_OFS_HANDOVR: idx = 3'(MSC_IDX_HANDOVR);
      default:         hit = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < MSC_NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (reg_req_in.wr && hit) begin
      regs_d[idx] = reg_req_in.wdata;
    end
    rdata_d = rdata_q;
    if (reg_req_in.rd) begin
      rdata_d = hit ? regs_q[idx] : MSC_RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < MSC_NUM_REGS; i++) begin
        regs_q[i] <= MSC_RST_REG;
      end
      rdata_q <= MSC_RDATA_UNMAPPED;
    end else begin
      regs_q  <= regs_d;
      rdata_q <= rdata_d;
    end
  end

  // Field decode from the live registers
  logic [7:0] r_adv;
  logic [7:0] r_det;
  logic [7:0] r_cur;
  logic [7:0] r_acc;
  logic [7:0] r_ho;
  logic [4:0] ho_code;

  assign r_adv   = regs_q[MSC_IDX_ADVANCE];
  assign r_det   = regs_q[MSC_IDX_DETECT];
  assign r_cur   = regs_q[MSC_IDX_CURRENT];
  assign r_acc   = regs_q[MSC_IDX_ACCEL];
  assign r_ho    = regs_q[MSC_IDX_HANDOVR];
  assign ho_code = r_ho[MSC_HO_LO +: 5];

  always_comb begin
    live_cfg = '0;
    live_cfg.advance_mode_select = r_adv[MSC_ADV_MODE_BIT];
    live_cfg.advance_time_value =
      11'(11'(r_adv[MSC_ADV_SIG_LO +: 4]) << r_adv[MSC_ADV_SHF_LO +: 3]);
    live_cfg.stationary_judge_ms = msc_stat_ms(r_det[MSC_STAT_LO +: 2]);
    live_cfg.inductive_sense_advance_deg =
      7'(7'd30 * (7'(r_det[MSC_IPD_LO +: 2]) + 7'd1));
    live_cfg.initial_speed_detect_enable = r_det[MSC_ISD_EN_BIT];
    live_cfg.reverse_drive_enable = r_det[MSC_RVS_EN_BIT];
    live_cfg.reverse_drive_threshold_dhz = msc_rvs_dhz(r_det[MSC_RVS_THR_LO +: 2]);
    live_cfg.open_loop_current_da = 5'(5'd2 << r_cur[MSC_OLCUR_LO +: 2]);
    live_cfg.open_loop_current_ramp_m = msc_ramp_m(r_cur[MSC_RAMP_LO +: 3]);
    live_cfg.brake_enable_flag = (r_cur[MSC_BRAKE_LO +: 3] != MSC_BRAKE_OFF);
    live_cfg.brake_duration_cs = msc_brake_cs(r_cur[MSC_BRAKE_LO +: 3]);
    live_cfg.startup_accel_second_c = msc_acc2_c(r_acc[MSC_ACC2_LO +: 3]);
    live_cfg.startup_accel_first_c = msc_acc1_c(r_acc[MSC_ACC1_LO +: 3]);
    if (r_ho[MSC_HO_RANGE_BIT]) begin
      live_cfg.loop_handover_threshold_dhz =
        12'((12'(ho_code[3:0]) + 12'd1) * MSC_HO_STEP1_DHZ);
      live_cfg.loop_handover_valid = 1'b1;
    end else begin
      live_cfg.loop_handover_threshold_dhz = 12'(12'(ho_code[3:0]) * MSC_HO_STEP0_DHZ);
      live_cfg.loop_handover_valid = (ho_code[3:0] != 4'h0);
    end
  end

  // Sequencer; snapshot keeps mid-run register writes from upsetting the drive
  assign start_take = start_in && !stop_in && (phase_q == MSC_IDLE);

  always_comb begin
    phase_d = phase_q;
    cfg_d   = cfg_q;
    case (phase_q)
      MSC_IDLE: begin
        if (start_take) begin
          cfg_d   = live_cfg;
          phase_d = MSC_OPEN_LOOP;
        end
      end
      MSC_OPEN_LOOP: begin
        if (stop_in) begin
          phase_d = MSC_IDLE;
        end else if (cfg_q.loop_handover_valid &&
                     (ol_freq_in >= FREQ_W'(cfg_q.loop_handover_threshold_dhz))) begin
          phase_d = MSC_CLOSED_LOOP;
        end
      end
      MSC_CLOSED_LOOP: begin
        if (stop_in) begin
          phase_d = MSC_IDLE;
        end
      end
      default: phase_d = MSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_q <= MSC_IDLE;
      cfg_q   <= '0;
    end else begin
      phase_q <= phase_d;
      cfg_q   <= cfg_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign cfg_out       = cfg_q;
  assign phase_out     = phase_q;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_adv_mode_snap: assert property (start_take |=> cfg_q.advance_mode_select == $past(r_adv[7]))
    else $error("advance mode not sampled at start");
  a_adv_time_calc: assert property (start_take |=>
      cfg_q.advance_time_value == 11'(11'($past(r_adv[3:0])) << $past(r_adv[6:4])))
    else $error("advance time wrong");
  a_stat_longest: assert property ((start_take && r_det[7:6] == 2'h3) |=> cfg_q.stationary_judge_ms == 10'd640)
    else $error("stationary time wrong");
  a_ipd_angle: assert property ((start_take && r_det[5:4] == 2'h2) |=> cfg_q.inductive_sense_advance_deg == 7'd90)
    else $error("advance angle wrong");
  a_isd_rvs_en: assert property (start_take |=> cfg_q.initial_speed_detect_enable == $past(r_det[3]) &&
      cfg_q.reverse_drive_enable == $past(r_det[2]))
    else $error("detect enables wrong");
  a_rvs_thr: assert property ((start_take && r_det[1:0] == 2'h1) |=> cfg_q.reverse_drive_threshold_dhz == 9'd130)
    else $error("reverse threshold wrong");
  a_ol_current: assert property ((start_take && r_cur[7:6] == 2'h3) |=> cfg_q.open_loop_current_da == 5'd16)
    else $error("open loop current wrong");
  a_ramp_slow: assert property ((start_take && r_cur[5:3] == 3'h7) |=> cfg_q.open_loop_current_ramp_m == 13'd23)
    else $error("ramp rate wrong");
  a_brake_off: assert property ((start_take && r_cur[2:0] == 3'h0) |=>
      !cfg_q.brake_enable_flag && cfg_q.brake_duration_cs == 9'd0)
    else $error("brake not disabled");
  a_accel_codes: assert property ((start_take && r_acc[5:0] == 6'h00) |=>
      cfg_q.startup_accel_second_c == 13'd5700 && cfg_q.startup_accel_first_c == 13'd7600)
    else $error("acceleration wrong");
  a_ho_range1: assert property ((start_take && r_ho[7:3] == 5'h1f) |=>
      cfg_q.loop_handover_threshold_dhz == 12'd2048)
    else $error("handover range 1 wrong");
  a_ho_zero_inval: assert property ((start_take && r_ho[7:3] == 5'h00) |=> !cfg_q.loop_handover_valid)
    else $error("zero handover code taken as valid");
  a_handover_move: assert property ((phase_q == MSC_OPEN_LOOP && !stop_in && cfg_q.loop_handover_valid &&
      ol_freq_in >= FREQ_W'(cfg_q.loop_handover_threshold_dhz)) |=> phase_q == MSC_CLOSED_LOOP)
    else $error("handover missed");
  a_cfg_held: assert property ((phase_q != MSC_IDLE && !$past(start_take)) |-> $stable(cfg_q))
    else $error("snapshot changed during run");

  // Decode spot checks at the start-up snapshot
  a_adv_fixed: assert property ((start_take && !r_adv[MSC_ADV_MODE_BIT]) |=>
      !cfg_q.advance_mode_select)
    else $error("fixed advance mode not kept");
  a_adv_time_max: assert property ((start_take && r_adv[MSC_ADV_SIG_LO +: 7] == 7'h7f) |=>
      cfg_q.advance_time_value == 11'd1920)
    else $error("largest advance time wrong");
  a_adv_time_zero: assert property ((start_take && r_adv[MSC_ADV_SIG_LO +: 4] == 4'h0) |=>
      cfg_q.advance_time_value == 11'd0)
    else $error("zero advance time wrong");
  a_stat_short: assert property ((start_take && r_det[MSC_STAT_LO +: 2] == 2'h0) |=>
      cfg_q.stationary_judge_ms == 10'd80)
    else $error("shortest stationary time wrong");
  a_stat_mid: assert property ((start_take && r_det[MSC_STAT_LO +: 2] == 2'h1) |=>
      cfg_q.stationary_judge_ms == 10'd160)
    else $error("second stationary time wrong");
  a_ipd_first: assert property ((start_take && r_det[MSC_IPD_LO +: 2] == 2'h0) |=>
      cfg_q.inductive_sense_advance_deg == 7'd30)
    else $error("smallest advance angle wrong");
  a_ipd_last: assert property ((start_take && r_det[MSC_IPD_LO +: 2] == 2'h3) |=>
      cfg_q.inductive_sense_advance_deg == 7'd120)
    else $error("largest advance angle wrong");
  a_rvs_drive_en: assert property (start_take |=>
      cfg_q.reverse_drive_enable == $past(r_det[MSC_RVS_EN_BIT]))
    else $error("reverse drive enable not sampled at start");
  a_rvs_thr_low: assert property ((start_take && r_det[MSC_RVS_THR_LO +: 2] == 2'h0) |=>
      cfg_q.reverse_drive_threshold_dhz == 9'd63)
    else $error("lowest reverse threshold wrong");
  a_rvs_thr_high: assert property ((start_take && r_det[MSC_RVS_THR_LO +: 2] == 2'h3) |=>
      cfg_q.reverse_drive_threshold_dhz == 9'd510)
    else $error("highest reverse threshold wrong");
  a_ol_cur_low: assert property ((start_take && r_cur[MSC_OLCUR_LO +: 2] == 2'h0) |=>
      cfg_q.open_loop_current_da == 5'd2)
    else $error("lowest open loop current wrong");
  a_ol_cur_mid: assert property ((start_take && r_cur[MSC_OLCUR_LO +: 2] == 2'h1) |=>
      cfg_q.open_loop_current_da == 5'd4)
    else $error("second open loop current wrong");
  a_ramp_fast: assert property ((start_take && r_cur[MSC_RAMP_LO +: 3] == 3'h0) |=>
      cfg_q.open_loop_current_ramp_m == 13'd6000)
    else $error("fastest ramp rate wrong");
  a_ramp_mid: assert property ((start_take && r_cur[MSC_RAMP_LO +: 3] == 3'h3) |=>
      cfg_q.open_loop_current_ramp_m == 13'd700)
    else $error("middle ramp rate wrong");
  a_brake_long: assert property ((start_take && r_cur[MSC_BRAKE_LO +: 3] == 3'h1) |=>
      cfg_q.brake_enable_flag && cfg_q.brake_duration_cs == 9'd270)
    else $error("longest brake time wrong");
  a_brake_short: assert property ((start_take && r_cur[MSC_BRAKE_LO +: 3] == 3'h7) |=>
      cfg_q.brake_enable_flag && cfg_q.brake_duration_cs == 9'd4)
    else $error("shortest brake time wrong");
  a_accel_second: assert property ((start_take && r_acc[MSC_ACC2_LO +: 3] == 3'h3) |=>
      cfg_q.startup_accel_second_c == 13'd690)
    else $error("second order acceleration wrong");
  a_accel_first: assert property ((start_take && r_acc[MSC_ACC1_LO +: 3] == 3'h7) |=>
      cfg_q.startup_accel_first_c == 13'd30)
    else $error("first order acceleration wrong");
  a_ho_range0: assert property ((start_take && r_ho[MSC_HO_LO +: 5] == 5'h0f) |=>
      cfg_q.loop_handover_valid && cfg_q.loop_handover_threshold_dhz == 12'd120)
    else $error("handover range 0 wrong");
  a_ho_range0_low: assert property ((start_take && r_ho[MSC_HO_LO +: 5] == 5'h01) |=>
      cfg_q.loop_handover_valid && cfg_q.loop_handover_threshold_dhz == 12'd8)
    else $error("lowest handover threshold wrong");
  a_ho_range1_low: assert property ((start_take && r_ho[MSC_HO_LO +: 5] == 5'h10) |=>
      cfg_q.loop_handover_valid && cfg_q.loop_handover_threshold_dhz == 12'd128)
    else $error("lowest range 1 threshold wrong");

  // Sequencer phase checks
  a_start_open: assert property (start_take |=>
      phase_q == MSC_OPEN_LOOP)
    else $error("start did not open the loop");
  a_idle_hold: assert property ((phase_q == MSC_IDLE && !start_take) |=>
      phase_q == MSC_IDLE)
    else $error("left idle without start");
  a_stop_idle: assert property ((phase_q != MSC_IDLE && stop_in) |=>
      phase_q == MSC_IDLE)
    else $error("stop did not return to idle");
  a_closed_held: assert property ((phase_q == MSC_CLOSED_LOOP && !stop_in) |=>
      phase_q == MSC_CLOSED_LOOP)
    else $error("closed loop left without stop");
  a_open_no_early: assert property ((phase_q == MSC_OPEN_LOOP && !stop_in && cfg_q.loop_handover_valid &&
      ol_freq_in < FREQ_W'(cfg_q.loop_handover_threshold_dhz)) |=> phase_q == MSC_OPEN_LOOP)
    else $error("handover before threshold");
  a_invalid_stay: assert property ((phase_q == MSC_OPEN_LOOP && !stop_in && !cfg_q.loop_handover_valid) |=>
      phase_q == MSC_OPEN_LOOP)
    else $error("invalid handover code left open loop");

  c_start: cover property (start_take ##1 phase_q == MSC_OPEN_LOOP);
  c_closed: cover property (phase_q == MSC_OPEN_LOOP ##1 phase_q == MSC_CLOSED_LOOP);
  c_stop: cover property (phase_q == MSC_CLOSED_LOOP ##1 phase_q == MSC_IDLE);
  c_rd_hit: cover property (reg_req_in.rd && hit);
  c_invalid_hold: cover property (phase_q == MSC_OPEN_LOOP && !cfg_q.loop_handover_valid ##1 phase_q == MSC_OPEN_LOOP);

endmodule : msc_startup_config

// ### sim/msc_motor_model.sv
// Motor stand-in: open-loop electrical frequency in 0.1 Hz steps.
// Assumes the sequencer phase output on the same clock.
`timescale 1ns/1ps
module msc_motor_model #(
  parameter int unsigned FREQ_W = 12
) (
  input  wire logic                clk_in,
  input  wire logic                srst_in,
  input  wire msc_pkg::msc_phase_t phase_in,
  output logic      [FREQ_W-1:0]   ol_freq_out
);
  import msc_pkg::*;
  logic [FREQ_W-1:0] freq_q;
  logic [FREQ_W-1:0] freq_d;
  // Rotor at rest while idle; one step a cycle so the crossing is exact
  always_comb begin
    freq_d = freq_q;
    if (phase_in == MSC_IDLE) begin
      freq_d = '0;
    end else if (freq_q != '1) begin
      freq_d = freq_q + 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    freq_q <= srst_in ? '0 : freq_d;
  end
  assign ol_freq_out = freq_q;
endmodule : msc_motor_model

// ### sim/test_motor_startup_control_config.sv
// Self-checking bench for the start-up configuration block.
// Assumes the motor stand-in model and the design package.
`timescale 1ns/1ps
module test_motor_startup_control_config;
  import msc_pkg::*;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  msc_regreq_t req = '0;
  logic        start_in = 1'b0;
  logic        stop_in = 1'b0;
  logic [11:0] ol_freq;
  logic [7:0]  rdata;
  msc_cfg_t    cfg;
  msc_phase_t  phase;
  logic [7:0]  mdl[5];
  int          n_fail = 0;
  int          n_checks = 0;
  int          seed = 9;
  int          cyc = 0;
  int          ramp_t[8] = '{6000, 3000, 1500, 700, 340, 160, 70, 23};
  int          brk_t[8] = '{0, 270, 130, 67, 33, 16, 8, 4};
  int          a2_t[8] = '{5700, 2900, 1400, 690, 330, 160, 66, 22};
  int          a1_t[8] = '{7600, 3800, 1900, 920, 450, 210, 90, 30};
  int          rvs_t[4] = '{63, 130, 260, 510};

  always #2.5 clk_in = ~clk_in;

  msc_startup_config #(.FREQ_W(12)) i_msc_startup_config (
    .clk_in(clk_in), .srst_in(srst_in), .reg_req_in(req), .start_in(start_in), .stop_in(stop_in),
    .ol_freq_in(ol_freq), .reg_rdata_out(rdata), .cfg_out(cfg), .phase_out(phase));
  msc_motor_model #(.FREQ_W(12)) i_msc_motor_model (
    .clk_in(clk_in), .srst_in(srst_in), .phase_in(phase), .ol_freq_out(ol_freq));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    if (a >= 8'h22 && a <= 8'h26) mdl[a-8'h22] = d;
    @(negedge clk_in);
    req = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_in);
    req = '0;
    @(negedge clk_in);
    chk(rdata === e, "read data");
  endtask : rd

  // Decoded snapshot worked out from the live register model
  function automatic msc_cfg_t exp_cfg();
    msc_cfg_t c;
    logic [4:0] h;
    c = '0;
    h = mdl[4][7:3];
    c.advance_mode_select = mdl[0][7];
    c.advance_time_value = 11'(11'(mdl[0][3:0]) << mdl[0][6:4]);
    c.stationary_judge_ms = 10'(80 << mdl[1][7:6]);
    c.inductive_sense_advance_deg = 7'(30 * (int'(mdl[1][5:4]) + 1));
    c.initial_speed_detect_enable = mdl[1][3];
    c.reverse_drive_enable = mdl[1][2];
    c.reverse_drive_threshold_dhz = 9'(rvs_t[mdl[1][1:0]]);
    c.open_loop_current_da = 5'(2 << mdl[2][7:6]);
    c.open_loop_current_ramp_m = 13'(ramp_t[mdl[2][5:3]]);
    c.brake_enable_flag = (mdl[2][2:0] != 3'h0);
    c.brake_duration_cs = 9'(brk_t[mdl[2][2:0]]);
    c.startup_accel_second_c = 13'(a2_t[mdl[3][5:3]]);
    c.startup_accel_first_c = 13'(a1_t[mdl[3][2:0]]);
    c.loop_handover_threshold_dhz = h[4] ? 12'((int'(h[3:0]) + 1) * 128) : 12'(int'(h[3:0]) * 8);
    c.loop_handover_valid = (h != 5'h00);
    return c;
  endfunction : exp_cfg

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    msc_cfg_t e;
    logic [11:0] f_prev;
    int k;
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h22 + 8'(i), 8'h00);
    wr(8'h27, 8'hff);
    wr(8'h21, 8'h5a);
    rd(8'h27, 8'h00);
    rd(8'h21, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 12; r++) begin
      for (int i = 0; i < 5; i++) wr(8'h22 + 8'(i), 8'($random(seed)));
      if (r == 1) wr(8'h26, 8'h07);
      if (r == 2) wr(8'h24, mdl[2] & 8'hf8);
      if (r == 3) wr(8'h26, 8'hff);
      for (int i = 0; i < 5; i++) rd(8'h22 + 8'(i), mdl[i]);
      e = exp_cfg();
      @(negedge clk_in);
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      chk(phase === MSC_OPEN_LOOP, "open loop after start");
      chk(cfg === e, "decoded snapshot");
      wr(8'h25, ~mdl[3]);
      wr(8'h23, ~mdl[1]);
      @(negedge clk_in);
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      chk(cfg === e, "snapshot held during run");
      f_prev = ol_freq;
      for (k = 0; k < 2200 && phase !== MSC_CLOSED_LOOP; k++) begin
        f_prev = ol_freq;
        @(negedge clk_in);
      end
      if (e.loop_handover_valid) begin
        chk(phase === MSC_CLOSED_LOOP, "closed loop reached");
        chk(f_prev === e.loop_handover_threshold_dhz, "handover at threshold");
      end else begin
        chk(phase === MSC_OPEN_LOOP, "invalid handover stays open");
      end
      @(negedge clk_in);
      stop_in = 1'b1;
      @(negedge clk_in);
      stop_in = 1'b0;
      chk(phase === MSC_IDLE, "idle after stop");
      $display("test run %0d done", r);
    end
    // Reset in the middle of a run
    wr(8'h22, 8'h5a);
    @(negedge clk_in);
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    chk(phase === MSC_IDLE && cfg === '0, "state after mid-run reset");
    for (int i = 0; i < 5; i++) rd(8'h22 + 8'(i), 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule : test_motor_startup_control_config
